// File: hdl/gpio_port_pkg.sv
// Purpose: Shared constants for the eight-bit bidirectional port.
// Assumes: Avalon-MM slave with 32-bit data; printed offsets are word indices.
// Notes:   Byte address of a register is four times its index.
package gpio_port_pkg;
   localparam int          PORT_WIDTH    = 8;
   localparam int          ADDR_WIDTH    = 8;
   localparam logic [7:0]  IDX_DIRECTION = 8'h12;
   localparam logic [7:0]  IDX_DATA      = 8'h13;
   localparam logic [7:0]  IDX_RMW_CTRL  = 8'h14;
   localparam logic [7:0]  IDX_STATUS    = 8'h15;
   localparam logic [7:0]  DIR_RESET     = 8'hff;
   localparam logic [7:0]  LATCH_RESET   = 8'h00;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   localparam int          RMW_OP_POS    = 8;
   localparam int          RMW_BIT_POS   = 0;
   localparam int          STAT_WARM_POS = 0;
   localparam int          STAT_LIVE_POS = 1;
   localparam int          SYNC_STAGES   = 3;

   typedef enum logic [1:0] {
      RMW_SET    = 2'b00,
      RMW_CLEAR  = 2'b01,
      RMW_TOGGLE = 2'b10,
      RMW_NONE   = 2'b11
   } rmw_op_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10,
      ST_DONE  = 2'b11
   } bus_state_t;
endpackage

// File: hdl/pin_sync.sv
// Purpose: Three-stage synchroniser for the port pin levels.
// Assumes: Pins are asynchronous to clock_i.
// Notes:   A bit changes once stages two and three agree.
module pin_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             nrst_i,
   // Pins
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
               level_o[g] <= 1'b0;
            end else if (s2_q[g] == s3_q[g]) begin
               level_o[g] <= s3_q[g];
            end
         end
      end
   endgenerate
endmodule

// File: hdl/pin_driver.sv
// Purpose: Per-pin output driver controlled by direction and latch.
// Assumes: Direction one means input.
// Notes:   Outputs are registered, one cycle after the register update.
module pin_driver #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             nrst_i,
   // Control
   input  wire logic [WIDTH-1:0] dir_i,
   input  wire logic [WIDTH-1:0] latch_i,
   // Pins
   output logic      [WIDTH-1:0] pin_o,
   output logic      [WIDTH-1:0] pin_oe_o
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_drv
         always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
               pin_oe_o[g] <= 1'b0;
               pin_o[g]    <= 1'b0;
            end else begin
               pin_oe_o[g] <= ~dir_i[g];
               pin_o[g]    <= latch_i[g];
            end
         end
      end
   endgenerate
endmodule

// File: hdl/bidirectional_gpio_port.sv
// Purpose: Eight-bit bidirectional port with direction and data registers.
// Assumes: Avalon-MM slave, one clock, pins sampled through three flops.
// Notes:   warm_rst_i models master-clear and watchdog resets.
//
// Implementation choice: the Avalon-MM slave port.
module bidirectional_gpio_port #(
   parameter int WIDTH = gpio_port_pkg::PORT_WIDTH
) (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic        warm_rst_i,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Port pins
   input  wire logic [WIDTH-1:0] port_pins_i,
   output logic      [WIDTH-1:0] port_pins_o,
   output logic      [WIDTH-1:0] port_pins_oe_o
);
   logic [WIDTH-1:0]          pin_direction_q;
   logic [WIDTH-1:0]          pin_data_q;
   logic [WIDTH-1:0]          pin_level;
   logic [WIDTH-1:0]          sample_q;
   logic [WIDTH-1:0]          rmw_result;
   logic [31:0]               rdata_q;
   logic                      wait_q;
   logic                      warm_seen_q;
   logic                      warm_d1_q;
   logic [7:0]                idx;
   logic                      word_ok;
   logic                      lane0;
   logic                      lane1;
   logic                      rmw_go;
   gpio_port_pkg::rmw_op_t    rmw_op;
   logic [2:0]                rmw_bit;
   gpio_port_pkg::bus_state_t state_q;
   logic [31:0]               wdata_q;
   logic [7:0]                widx_q;
   logic [3:0]                wbe_q;

   assign idx     = avs_address_i[9:2];
   assign word_ok = (avs_address_i[1:0] == 2'b00);
   assign lane0   = wbe_q[0];
   assign lane1   = wbe_q[1];
   assign rmw_op  = gpio_port_pkg::rmw_op_t'(wdata_q[gpio_port_pkg::RMW_OP_POS +: 2]);
   assign rmw_bit = wdata_q[gpio_port_pkg::RMW_BIT_POS +: 3];
   assign rmw_go  = (widx_q == gpio_port_pkg::IDX_RMW_CTRL) && lane1 && lane0 &&
                    (rmw_op != gpio_port_pkg::RMW_NONE);

   // Pin levels pass a three-flop synchroniser
   pin_sync #(
      .WIDTH (WIDTH)
   ) u_sync (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .pin_i   (port_pins_i),
      .level_o (pin_level)
   );

   // Driver enable is the inverse of direction
   pin_driver #(
      .WIDTH (WIDTH)
   ) u_drv (
      .clock_i  (clock_i),
      .nrst_i   (nrst_i),
      .dir_i    (pin_direction_q),
      .latch_i  (pin_data_q),
      .pin_o    (port_pins_o),
      .pin_oe_o (port_pins_oe_o)
   );

   // Bus sequencer: IDLE samples, READ or WRITE acts, DONE drops waitrequest
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= gpio_port_pkg::ST_IDLE;
      end else begin
         case (state_q)
            gpio_port_pkg::ST_IDLE: begin
               if (avs_read_i) begin
                  state_q <= gpio_port_pkg::ST_READ;
               end else if (avs_write_i) begin
                  state_q <= gpio_port_pkg::ST_WRITE;
               end
            end
            gpio_port_pkg::ST_READ:  state_q <= gpio_port_pkg::ST_DONE;
            gpio_port_pkg::ST_WRITE: state_q <= gpio_port_pkg::ST_DONE;
            gpio_port_pkg::ST_DONE:  state_q <= gpio_port_pkg::ST_IDLE;
            default:                 state_q <= gpio_port_pkg::ST_IDLE;
         endcase
      end
   end

   // Capture write request
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wdata_q <= 32'h0000_0000;
         widx_q  <= 8'h00;
         wbe_q   <= 4'h0;
      end else if (state_q == gpio_port_pkg::ST_IDLE && avs_write_i && !avs_read_i) begin
         wdata_q <= avs_writedata_i;
         widx_q  <= word_ok ? idx : 8'hff;
         wbe_q   <= avs_byteenable_i;
      end
   end

   // Pin sample taken at the start of every access
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sample_q <= '0;
      end else if (state_q == gpio_port_pkg::ST_IDLE && (avs_read_i || avs_write_i)) begin
         sample_q <= pin_level;
      end
   end

   // Modify on the sampled pin levels, not on the latch
   always_comb begin
      rmw_result = sample_q;
      case (rmw_op)
         gpio_port_pkg::RMW_SET:    rmw_result[rmw_bit] = 1'b1;
         gpio_port_pkg::RMW_CLEAR:  rmw_result[rmw_bit] = 1'b0;
         gpio_port_pkg::RMW_TOGGLE: rmw_result[rmw_bit] = ~sample_q[rmw_bit];
         default:                   rmw_result = sample_q;
      endcase
   end

   // Direction register: all inputs after any reset
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_direction_q <= gpio_port_pkg::DIR_RESET;
      end else if (warm_rst_i) begin
         pin_direction_q <= gpio_port_pkg::DIR_RESET;
      end else if (state_q == gpio_port_pkg::ST_WRITE && lane0 &&
                   widx_q == gpio_port_pkg::IDX_DIRECTION) begin
         pin_direction_q <= wdata_q[WIDTH-1:0];
      end
   end

   // Latches: defined only at cold reset, untouched by warm reset
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_data_q <= gpio_port_pkg::LATCH_RESET;
      end else if (state_q == gpio_port_pkg::ST_WRITE) begin
         if (lane0 && widx_q == gpio_port_pkg::IDX_DATA) begin
            pin_data_q <= wdata_q[WIDTH-1:0];
         end else if (rmw_go) begin
            pin_data_q <= rmw_result;
         end
      end
   end

   // Warm reset status flag, set wins over clear
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         warm_seen_q <= 1'b0;
         warm_d1_q   <= 1'b0;
      end else begin
         warm_d1_q <= warm_rst_i;
         if (warm_rst_i) begin
            warm_seen_q <= 1'b1;
         end else if (state_q == gpio_port_pkg::ST_WRITE && lane0 &&
                      widx_q == gpio_port_pkg::IDX_STATUS &&
                      wdata_q[gpio_port_pkg::STAT_WARM_POS]) begin
            warm_seen_q <= 1'b0;
         end
      end
   end

   // Read data
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (state_q == gpio_port_pkg::ST_READ) begin
         rdata_q <= gpio_port_pkg::UNMAPPED_READ;
         if (word_ok) begin
            case (idx)
               gpio_port_pkg::IDX_DIRECTION: rdata_q[WIDTH-1:0] <= pin_direction_q;
               gpio_port_pkg::IDX_DATA:      rdata_q[WIDTH-1:0] <= sample_q;
               gpio_port_pkg::IDX_STATUS: begin
                  rdata_q[gpio_port_pkg::STAT_WARM_POS] <= warm_seen_q;
                  rdata_q[gpio_port_pkg::STAT_LIVE_POS] <= |(~pin_direction_q);
               end
               default: rdata_q <= gpio_port_pkg::UNMAPPED_READ;
            endcase
         end
      end
   end

   // Waitrequest low only in DONE
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !(state_q == gpio_port_pkg::ST_READ ||
                     state_q == gpio_port_pkg::ST_WRITE);
      end
   end

   assign avs_readdata_o    = rdata_q;
   assign avs_waitrequest_o = wait_q;

   a_dir_warm_reset: assert property (@(posedge clock_i) disable iff (!nrst_i)
      warm_rst_i |=> pin_direction_q == 8'hff)
      else $error("Direction not all inputs after warm reset");

   a_latch_keep_warm: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (warm_rst_i && state_q != gpio_port_pkg::ST_WRITE) |=> $stable(pin_data_q))
      else $error("Latch changed on warm reset");

   a_oe_follows_dir: assert property (@(posedge clock_i) disable iff (!nrst_i)
      ##1 port_pins_oe_o == ~$past(pin_direction_q))
      else $error("Output enable does not follow direction");

   a_drive_latch: assert property (@(posedge clock_i) disable iff (!nrst_i)
      $fell(pin_direction_q[0]) |=> (port_pins_oe_o[0] && port_pins_o[0] == $past(pin_data_q[0])))
      else $error("New output not driven from latch");

   a_out_value: assert property (@(posedge clock_i) disable iff (!nrst_i)
      ##1 port_pins_o == $past(pin_data_q))
      else $error("Pin output not latch value");

   a_data_write: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (state_q == gpio_port_pkg::ST_WRITE && lane0 && widx_q == gpio_port_pkg::IDX_DATA)
      |=> pin_data_q == $past(wdata_q[7:0]))
      else $error("Data write did not load latch");

   a_rmw_pins: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (state_q == gpio_port_pkg::ST_WRITE && rmw_go && widx_q != gpio_port_pkg::IDX_DATA)
      |=> (pin_data_q & ~(8'h01 << $past(rmw_bit))) ==
          ($past(sample_q) & ~(8'h01 << $past(rmw_bit))))
      else $error("RMW did not copy pin levels");

   a_read_pins: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (state_q == gpio_port_pkg::ST_IDLE && avs_read_i && word_ok &&
       idx == gpio_port_pkg::IDX_DATA)
      |=> ##1 avs_readdata_o[7:0] == $past(pin_level, 2))
      else $error("Data read not pin sample at start");

   a_wait_answer: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (state_q == gpio_port_pkg::ST_IDLE && (avs_read_i || avs_write_i))
      |=> ##1 !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("Waitrequest timing wrong");
endmodule

// File: test/pin_world.sv
// Purpose: Model of the outside circuitry on the eight port pins.
// Assumes: The bench chooses the level driven onto undriven pins.
// Notes:   Pins the device drives read back as the device drives them.
module pin_world (
   // Device side
   input  wire logic [7:0] pins_o_i,
   input  wire logic [7:0] pins_oe_i,
   // Bench control
   input  wire logic [7:0] ext_i,
   // Wire level
   output logic      [7:0] level_o
);
   // No contention: outside source yields where the device drives
   assign level_o = (pins_oe_i & pins_o_i) | (~pins_oe_i & ext_i);
endmodule

// File: test/bidirectional_gpio_port_test.sv
// Purpose: Register-level checks of the bidirectional port.
// Assumes: Avalon-MM word registers at byte address four times the index.
// Notes:   Cold reset latch value taken as zero.
module bidirectional_gpio_port_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        warm_rst_i = 1'b0;
   logic [9:0]  avs_address_i = 10'h000;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic [7:0]  pins_lvl;
   logic [7:0]  pins_o;
   logic [7:0]  pins_oe;
   logic [7:0]  ext = 8'h3c;
   logic [7:0]  latch_m;
   logic [7:0]  dir_m;
   logic [7:0]  lvl;
   logic [31:0] rd;
   int          error_cnt = 0;
   int          n_tests = 0;
   logic [1:0]  ops [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   logic [2:0]  bits [4] = '{3'h1, 3'h7, 3'h5, 3'h3};

   always #50 clock_i = ~clock_i;

   bidirectional_gpio_port i_dut (
      .clock_i          (clock_i),
      .nrst_i           (nrst_i),
      .warm_rst_i       (warm_rst_i),
      .avs_address_i    (avs_address_i),
      .avs_read_i       (avs_read_i),
      .avs_write_i      (avs_write_i),
      .avs_byteenable_i (4'hf),
      .avs_writedata_i  (avs_writedata_i),
      .avs_readdata_o   (avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .port_pins_i      (pins_lvl),
      .port_pins_o      (pins_o),
      .port_pins_oe_o   (pins_oe)
   );

   pin_world i_world (
      .pins_o_i (pins_o),
      .pins_oe_i(pins_oe),
      .ext_i    (ext),
      .level_o  (pins_lvl)
   );

   task automatic complete_run();
      $display("Counts: %0d compared, %0d mismatched", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One bus access; request held until waitrequest is sampled low at a rising edge
   task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      @(posedge clock_i);
      while (avs_waitrequest_o !== 1'b0) begin
         n++;
         if (n > 50) begin
            error_cnt++;
            $display("[FAIL] bus timeout at %h", a);
            complete_run();
         end
         @(posedge clock_i);
      end
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      // Idle edge so a following call never reassigns the strobes in this step
      @(posedge clock_i);
   endtask

   task automatic reg_wr(input logic [7:0] idx, input logic [31:0] d);
      access(1'b1, {idx, 2'b00}, d);
      repeat (6) @(posedge clock_i);
   endtask

   task automatic reg_rd(input logic [7:0] idx);
      access(1'b0, {idx, 2'b00}, 32'h0);
   endtask

   function automatic logic [7:0] level_of();
      return (latch_m & ~dir_m) | (ext & dir_m);
   endfunction

   initial begin
      repeat (20) @(posedge clock_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      reg_rd(gpio_port_pkg::IDX_DIRECTION);
      check("dir reset", rd, 32'h0000_00ff);
      check("oe reset", {24'h0, pins_oe}, 32'h0);
      reg_rd(gpio_port_pkg::IDX_DATA);
      check("data read pins", rd, {24'h0, ext});
      $display("Test reset done");
      latch_m = 8'ha5;
      reg_wr(gpio_port_pkg::IDX_DATA, {24'h0, latch_m});
      check("latch while input", {24'h0, pins_o}, {24'h0, latch_m});
      reg_rd(gpio_port_pkg::IDX_DATA);
      check("read not latch", rd, {24'h0, ext});
      dir_m = 8'h0f;
      reg_wr(gpio_port_pkg::IDX_DIRECTION, {24'h0, dir_m});
      check("oe mixed", {24'h0, pins_oe}, {24'h0, ~dir_m});
      reg_rd(gpio_port_pkg::IDX_DATA);
      check("mixed level", rd, {24'h0, level_of()});
      reg_rd(gpio_port_pkg::IDX_STATUS);
      check("status output", rd & 32'h2, 32'h2);
      $display("Test direction done");
      for (int i = 0; i < 4; i++) begin
         lvl = level_of();
         case (ops[i])
            2'h0: latch_m = lvl | (8'h01 << bits[i]);
            2'h1: latch_m = lvl & ~(8'h01 << bits[i]);
            2'h2: latch_m = lvl ^ (8'h01 << bits[i]);
            default: latch_m = latch_m;
         endcase
         reg_wr(gpio_port_pkg::IDX_RMW_CTRL, {22'h0, ops[i], 5'h0, bits[i]});
         check("rmw latch", {24'h0, pins_o}, {24'h0, latch_m});
         reg_rd(gpio_port_pkg::IDX_DATA);
         check("rmw level", rd, {24'h0, level_of()});
      end
      $display("Test read-modify-write done");
      reg_rd(8'h20);
      check("unmapped read", rd, 32'h0);
      access(1'b1, {8'h20, 2'b00}, 32'h0);
      access(1'b0, 10'h049, 32'h0);
      check("misaligned read", rd, 32'h0);
      reg_rd(gpio_port_pkg::IDX_DIRECTION);
      check("dir kept", rd, {24'h0, dir_m});
      $display("Test unmapped done");
      warm_rst_i <= 1'b1;
      @(posedge clock_i);
      warm_rst_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      dir_m = 8'hff;
      reg_rd(gpio_port_pkg::IDX_DIRECTION);
      check("warm dir", rd, 32'h0000_00ff);
      check("warm oe", {24'h0, pins_oe}, 32'h0);
      check("warm latch", {24'h0, pins_o}, {24'h0, latch_m});
      reg_rd(gpio_port_pkg::IDX_STATUS);
      check("warm status", rd, 32'h1);
      reg_wr(gpio_port_pkg::IDX_STATUS, 32'h1);
      reg_rd(gpio_port_pkg::IDX_STATUS);
      check("status cleared", rd, 32'h0);
      $display("Test warm reset done");
      reg_wr(gpio_port_pkg::IDX_DIRECTION, 32'h0);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      check("cold oe", {24'h0, pins_oe}, 32'h0);
      nrst_i <= 1'b1;
      @(posedge clock_i);
      reg_rd(gpio_port_pkg::IDX_DIRECTION);
      check("cold dir", rd, 32'h0000_00ff);
      $display("Test cold reset done");
      complete_run();
   end
endmodule
